/* File: common/timer_pkg.sv */
// Purpose: Shared constants for the dual timer/counter block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   Registers carry 8 bits in the low lane, upper bits read zero
package timer_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_MODE    = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_T0_LOW  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_T0_HIGH = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_T1_LOW  = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_T1_HIGH = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_IRQ_EN  = 8'h18;

    // Control register fields
    localparam int unsigned CTL_T1_FLAG = 7;
    localparam int unsigned CTL_T1_RUN  = 6;
    localparam int unsigned CTL_T0_FLAG = 5;
    localparam int unsigned CTL_T0_RUN  = 4;

    // Mode register fields
    localparam int unsigned MOD_T1_GATE = 7;
    localparam int unsigned MOD_T1_SRC  = 6;
    localparam int unsigned MOD_T1_HI   = 5;
    localparam int unsigned MOD_T1_LO   = 4;
    localparam int unsigned MOD_T0_GATE = 3;
    localparam int unsigned MOD_T0_SRC  = 2;
    localparam int unsigned MOD_T0_HI   = 1;
    localparam int unsigned MOD_T0_LO   = 0;

    // Interrupt enable register fields
    localparam int unsigned IEN_GLOBAL = 7;
    localparam int unsigned IEN_T1     = 3;
    localparam int unsigned IEN_T0     = 1;

    // Mode field encodings
    localparam logic [1:0] MODE_13BIT  = 2'h0;
    localparam logic [1:0] MODE_16BIT  = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT  = 2'h3;

    localparam logic [7:0] REG_RESET = 8'h00;

    // Peripheral clock periods per peripheral cycle
    localparam int unsigned PER_CYCLE_CLKS = 6;
    localparam int unsigned DIV_W          = 3;
endpackage : timer_pkg

/* File: common/count_tick_if.sv */
// Purpose: Carries the peripheral-cycle tick and qualified pin events
// Assumes: Single clock domain, clk_sys
// Notes:   Edge strobes are only ever high together with per_tick
`timescale 1ns/1ps
interface count_tick_if;
    logic per_tick;
    logic t0_edge;
    logic t1_edge;
    logic t0_pin_gating_lvl;
    logic t1_pin_gating_lvl;

    modport gen  (output per_tick, output t0_edge, output t1_edge, output t0_pin_gating_lvl, output t1_pin_gating_lvl);
    modport user (input per_tick, input t0_edge, input t1_edge, input t0_pin_gating_lvl, input t1_pin_gating_lvl);
endinterface : count_tick_if

/* File: rtl/count_tick_gen.sv */
// Purpose: Peripheral-cycle divider, pin synchronisers, falling-edge detect
// Assumes: Pins are asynchronous to clk_sys
// Notes:   Count pins are sampled once per peripheral cycle, gate pins every clock
`timescale 1ns/1ps
module count_tick_gen #(
    parameter logic [timer_pkg::DIV_W-1:0] DIV_LAST = timer_pkg::DIV_W'(timer_pkg::PER_CYCLE_CLKS - 1)
) (
    input  wire logic   clk_sys,
    input  wire logic   reset_n,
    input  wire logic   t0_count_pin,
    input  wire logic   t1_count_pin,
    input  wire logic   ext_irq_pin_zero,
    input  wire logic   ext_irq_pin_one,
    count_tick_if.gen   tk
);
    logic [timer_pkg::DIV_W-1:0] div_q;
    logic [3:0]                  pins;
    logic [3:0]                  sync1_q;
    logic [3:0]                  sync2_q;
    logic [1:0]                  smp_q;
    logic                        tick;

    assign pins = {ext_irq_pin_one, ext_irq_pin_zero, t1_count_pin, t0_count_pin};

    // One tick every six clocks
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            div_q <= '0;
        end else if (div_q == DIV_LAST) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + timer_pkg::DIV_W'(1);
        end
    end

    assign tick = (div_q == DIV_LAST);

    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_sync
            always_ff @(posedge clk_sys) begin
                if (!reset_n) begin
                    sync1_q[i] <= 1'b0;
                    sync2_q[i] <= 1'b0;
                end else begin
                    sync1_q[i] <= pins[i];
                    sync2_q[i] <= sync1_q[i];
                end
            end
        end
    endgenerate

    // Previous per-cycle sample of the count pins
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            smp_q <= 2'h0;
        end else if (tick) begin
            smp_q <= sync2_q[1:0];
        end
    end

    assign tk.per_tick  = tick;
    // High sample then low sample counts one edge
    assign tk.t0_edge   = tick & smp_q[0] & ~sync2_q[0];
    assign tk.t1_edge   = tick & smp_q[1] & ~sync2_q[1];
    assign tk.t0_pin_gating_lvl = sync2_q[2];
    assign tk.t1_pin_gating_lvl = sync2_q[3];
endmodule : count_tick_gen

/* File: rtl/dual_timer.sv */
// Purpose: Two timer/counters with four modes, APB register access
// Assumes: Single clock clk_sys at 20 MHz, synchronous active-low reset
// Notes:   Zero-wait APB slave, unmapped addresses answer pslverr
//
// Contract
// - Timer 0 reload mode reloads low from high
// - Reload keeps high byte; writes always accepted
// - Split mode: low byte uses timer 0 controls
// - Split high byte counts ticks, timer 1 run/flag
// - Timer 1 mode 3 holds its count
// - Timer 1 mode 0 is 13-bit, prescale 32
// - Timer 1 mode 1 is 16-bit cascade
// - Timer 1 mode 2 reloads low from high
// - Gate set needs pin high to count
// - Rollover sets flag and requests interrupt
// - Timer 1 controls in upper mode nibble
// - Flag cleared on vectoring, set on overflow
// - Request needs timer and global enables
// - Timer 1 overflow drives baud tick
// - Timer source increments once per six clocks
// - Counter source counts sampled falling edges
// - Timer 0 mode 0 is 13-bit, prescale 32
// - Timer 0 mode 1 is 16-bit cascade
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
module dual_timer (
    input  wire logic                         clk_sys,
    input  wire logic                         reset_n,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [timer_pkg::ADDR_W-1:0] paddr,
    input  wire logic [timer_pkg::DATA_W-1:0] pwdata,
    output logic      [timer_pkg::DATA_W-1:0] prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire logic                         t0_count_pin,
    input  wire logic                         t1_count_pin,
    input  wire logic                         ext_irq_pin_zero,
    input  wire logic                         ext_irq_pin_one,
    input  wire logic                         t0_irq_ack,
    input  wire logic                         t1_irq_ack,
    output logic                              t0_irq_req,
    output logic                              t1_irq_req,
    output logic                              t1_overflow_tick
);
    typedef enum {SEL_NONE, SEL_CONTROL, SEL_MODE, SEL_T0L, SEL_T0H, SEL_T1L, SEL_T1H, SEL_IEN} reg_sel_t;

    logic [7:0] timer_control_reg_q;
    logic [7:0] timer_mode_reg_q;
    logic [7:0] irq_enable_reg_q;
    logic [7:0] t0_count_low_q;
    logic [7:0] t0_count_low_d;
    logic [7:0] t0_count_high_q;
    logic [7:0] t0_count_high_d;
    logic [7:0] t1_count_low_q;
    logic [7:0] t1_count_low_d;
    logic [7:0] t1_count_high_q;
    logic [7:0] t1_count_high_d;
    logic       t0_overflow_flag_q;
    logic       t1_overflow_flag_q;
    logic       t1_overflow_tick_q;
    logic [timer_pkg::DATA_W-1:0] prdata_q;
    logic       t0_ovf;
    logic       t1_ovf;
    logic       split_hi_ovf;
    logic       wr_en;
    logic       rd_setup;
    reg_sel_t   sel;
    logic [7:0] wbyte;

    count_tick_if tk ();

    count_tick_gen u_tick (
        .clk_sys          (clk_sys),
        .reset_n          (reset_n),
        .t0_count_pin     (t0_count_pin),
        .t1_count_pin     (t1_count_pin),
        .ext_irq_pin_zero (ext_irq_pin_zero),
        .ext_irq_pin_one  (ext_irq_pin_one),
        .tk               (tk.gen)
    );

    // Address decode shared by read and write paths
    function automatic reg_sel_t decode(input logic [timer_pkg::ADDR_W-1:0] a);
        case (a)
            timer_pkg::OFS_CONTROL: decode = SEL_CONTROL;
            timer_pkg::OFS_MODE:    decode = SEL_MODE;
            timer_pkg::OFS_T0_LOW:  decode = SEL_T0L;
            timer_pkg::OFS_T0_HIGH: decode = SEL_T0H;
            timer_pkg::OFS_T1_LOW:  decode = SEL_T1L;
            timer_pkg::OFS_T1_HIGH: decode = SEL_T1H;
            timer_pkg::OFS_IRQ_EN:  decode = SEL_IEN;
            default:                decode = SEL_NONE;
        endcase
    endfunction : decode

    // One increment step in modes 0 to 2 and split low byte; result {ovf, low, high}
    function automatic logic [16:0] step(input logic [1:0] mode, input logic [7:0] lo, input logic [7:0] hi);
        logic [5:0] p;
        logic [8:0] l;
        logic [8:0] h;
        p = {1'b0, lo[4:0]} + 6'h01;
        l = {1'b0, lo} + 9'h001;
        h = {1'b0, hi} + 9'h001;
        case (mode)
            timer_pkg::MODE_13BIT: begin
                // Upper three low-byte bits stay put
                if (p[5]) begin
                    step = {h[8], lo[7:5], p[4:0], h[7:0]};
                end else begin
                    step = {1'b0, lo[7:5], p[4:0], hi};
                end
            end
            timer_pkg::MODE_16BIT: begin
                // Low carry feeds high byte
                if (l[8]) begin
                    step = {h[8], l[7:0], h[7:0]};
                end else begin
                    step = {1'b0, l[7:0], hi};
                end
            end
            timer_pkg::MODE_RELOAD: begin
                // Reload from high, high untouched
                if (l[8]) begin
                    step = {1'b1, hi, hi};
                end else begin
                    step = {1'b0, l[7:0], hi};
                end
            end
            default: begin
                step = {l[8], l[7:0], hi};
            end
        endcase
    endfunction : step

    // Zero-wait slave
    assign pready   = 1'b1;
    assign sel      = decode(paddr);
    assign pslverr  = psel & penable & (sel == SEL_NONE);
    assign wr_en    = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign wbyte    = pwdata[7:0];

    // Counting engine
    logic [1:0]  t0_mode;
    logic [1:0]  t1_mode;
    logic        t0_split;
    logic        t0_en;
    logic        t0h_en;
    logic        t1_en;
    logic        t0_src_ok;
    logic        t1_src_ok;
    logic        t0_gate_ok;
    logic        t1_gate_ok;
    logic [16:0] t0_step;
    logic [16:0] t1_step;
    logic [8:0]  t0h_inc;

    // Two-bit field, high bit first
    assign t0_mode  = {timer_mode_reg_q[timer_pkg::MOD_T0_HI], timer_mode_reg_q[timer_pkg::MOD_T0_LO]};
    assign t1_mode  = {timer_mode_reg_q[timer_pkg::MOD_T1_HI], timer_mode_reg_q[timer_pkg::MOD_T1_LO]};
    assign t0_split = (t0_mode == timer_pkg::MODE_SPLIT);

    // Timer source counts ticks, counter source counts pin edges
    assign t0_src_ok = timer_mode_reg_q[timer_pkg::MOD_T0_SRC] ? tk.t0_edge : tk.per_tick;
    assign t1_src_ok = timer_mode_reg_q[timer_pkg::MOD_T1_SRC] ? tk.t1_edge : tk.per_tick;

    // Gate clear: run alone; gate set: pin must be high too
    assign t0_gate_ok = ~timer_mode_reg_q[timer_pkg::MOD_T0_GATE] | tk.t0_pin_gating_lvl;
    assign t1_gate_ok = ~timer_mode_reg_q[timer_pkg::MOD_T1_GATE] | tk.t1_pin_gating_lvl;

    assign t0_en = timer_control_reg_q[timer_pkg::CTL_T0_RUN] & t0_gate_ok & t0_src_ok;

    // Split mode lends timer 1's run bit to timer 0 high, so timer 1 free-runs
    assign t1_en = (t0_split | timer_control_reg_q[timer_pkg::CTL_T1_RUN]) & t1_gate_ok & t1_src_ok
                   & (t1_mode != timer_pkg::MODE_SPLIT);

    // Split high byte: fixed tick source, timer 1 run bit
    assign t0h_en  = t0_split & tk.per_tick & timer_control_reg_q[timer_pkg::CTL_T1_RUN];
    assign t0h_inc = {1'b0, t0_count_high_q} + 9'h001;

    assign t0_step = step(t0_mode, t0_count_low_q, t0_count_high_q);
    assign t1_step = step(t1_mode, t1_count_low_q, t1_count_high_q);

    always_comb begin
        t0_count_low_d  = t0_count_low_q;
        t0_count_high_d = t0_count_high_q;
        t1_count_low_d  = t1_count_low_q;
        t1_count_high_d = t1_count_high_q;
        t0_ovf          = 1'b0;
        t1_ovf          = 1'b0;
        split_hi_ovf    = 1'b0;
        if (t0_en) begin
            t0_count_low_d = t0_step[15:8];
            t0_ovf         = t0_step[16];
            if (!t0_split) begin
                t0_count_high_d = t0_step[7:0];
            end
        end
        if (t0h_en) begin
            t0_count_high_d = t0h_inc[7:0];
            split_hi_ovf    = t0h_inc[8];
        end
        if (t1_en) begin
            t1_count_low_d  = t1_step[15:8];
            t1_count_high_d = t1_step[7:0];
            t1_ovf          = t1_step[16];
        end
        // Processor byte write wins over hardware
        if (wr_en && sel == SEL_T0L) begin
            t0_count_low_d = wbyte;
        end
        if (wr_en && sel == SEL_T0H) begin
            t0_count_high_d = wbyte;
        end
        if (wr_en && sel == SEL_T1L) begin
            t1_count_low_d = wbyte;
        end
        if (wr_en && sel == SEL_T1H) begin
            t1_count_high_d = wbyte;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            t0_count_low_q  <= timer_pkg::REG_RESET;
            t0_count_high_q <= timer_pkg::REG_RESET;
            t1_count_low_q  <= timer_pkg::REG_RESET;
            t1_count_high_q <= timer_pkg::REG_RESET;
        end else begin
            t0_count_low_q  <= t0_count_low_d;
            t0_count_high_q <= t0_count_high_d;
            t1_count_low_q  <= t1_count_low_d;
            t1_count_high_q <= t1_count_high_d;
        end
    end

    // Mode and enable registers; behaviour while running is software's concern
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            timer_mode_reg_q <= timer_pkg::REG_RESET;
            irq_enable_reg_q <= timer_pkg::REG_RESET;
        end else if (wr_en) begin
            if (sel == SEL_MODE) begin
                timer_mode_reg_q <= wbyte;
            end
            if (sel == SEL_IEN) begin
                irq_enable_reg_q <= wbyte;
            end
        end
    end

    // Control bits other than the two flags are plain storage
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            timer_control_reg_q <= timer_pkg::REG_RESET;
        end else if (wr_en && sel == SEL_CONTROL) begin
            timer_control_reg_q <= wbyte;
        end
    end

    // Flags: set beats vectoring clear and software write
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            t0_overflow_flag_q <= 1'b0;
        end else if (t0_ovf) begin
            t0_overflow_flag_q <= 1'b1;
        end else if (wr_en && sel == SEL_CONTROL) begin
            t0_overflow_flag_q <= wbyte[timer_pkg::CTL_T0_FLAG];
        end else if (t0_irq_ack) begin
            t0_overflow_flag_q <= 1'b0;
        end
    end

    // Split mode: timer 1 flag belongs to timer 0 high byte
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            t1_overflow_flag_q <= 1'b0;
        end else if (split_hi_ovf || (t1_ovf && !t0_split)) begin
            t1_overflow_flag_q <= 1'b1;
        end else if (wr_en && sel == SEL_CONTROL) begin
            t1_overflow_flag_q <= wbyte[timer_pkg::CTL_T1_FLAG];
        end else if (t1_irq_ack) begin
            t1_overflow_flag_q <= 1'b0;
        end
    end

    // Baud tick follows timer 1 rollover in modes 0 to 2; none in mode 3
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            t1_overflow_tick_q <= 1'b0;
        end else begin
            t1_overflow_tick_q <= t1_ovf;
        end
    end

    assign t1_overflow_tick = t1_overflow_tick_q;

    // Request gated by own and global enables
    assign t0_irq_req = t0_overflow_flag_q & irq_enable_reg_q[timer_pkg::IEN_T0]
                        & irq_enable_reg_q[timer_pkg::IEN_GLOBAL];
    assign t1_irq_req = t1_overflow_flag_q & irq_enable_reg_q[timer_pkg::IEN_T1]
                        & irq_enable_reg_q[timer_pkg::IEN_GLOBAL];

    // Read data captured in the setup cycle so it comes from a flop
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            prdata_q <= '0;
        end else if (rd_setup) begin
            case (sel)
                SEL_CONTROL: begin
                    prdata_q <= {24'h000000, t1_overflow_flag_q, timer_control_reg_q[timer_pkg::CTL_T1_RUN],
                                 t0_overflow_flag_q, timer_control_reg_q[timer_pkg::CTL_T0_RUN],
                                 timer_control_reg_q[3:0]};
                end
                SEL_MODE: prdata_q <= {24'h000000, timer_mode_reg_q};
                SEL_T0L:  prdata_q <= {24'h000000, t0_count_low_q};
                SEL_T0H:  prdata_q <= {24'h000000, t0_count_high_q};
                SEL_T1L:  prdata_q <= {24'h000000, t1_count_low_q};
                SEL_T1H:  prdata_q <= {24'h000000, t1_count_high_q};
                SEL_IEN:  prdata_q <= {24'h000000, irq_enable_reg_q};
                default:  prdata_q <= '0;
            endcase
        end
    end

    assign prdata = prdata_q;
endmodule : dual_timer

/* File: bench/dual_timer_chk.sv */
// Purpose: Port-level checks of the dual timer
// Assumes: Zero-wait APB slave, registered baud tick
// Notes:   Flags stand until ack or a register write
`timescale 1ns/1ps
module dual_timer_chk (
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        t0_irq_ack,
    input wire logic        t1_irq_ack,
    input wire logic        t0_irq_req,
    input wire logic        t1_irq_req,
    input wire logic        t1_overflow_tick
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    property p_ready; psel && penable |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low in access");
    property p_err; pslverr |-> psel && penable; endproperty
    a_err: assert property (p_err) else $error("pslverr outside access");
    property p_rdhold; psel && penable |=> $stable(prdata); endproperty
    a_rdhold: assert property (p_rdhold) else $error("read data moved");
    // Ticks come at most once per peripheral cycle
    property p_tick; t1_overflow_tick |=> !t1_overflow_tick [*5]; endproperty
    a_tick: assert property (p_tick) else $error("baud tick too close");
    property p_fall0; $fell(t0_irq_req) |-> $past(t0_irq_ack) || $past(psel && penable && pwrite); endproperty
    a_fall0: assert property (p_fall0) else $error("t0 request dropped");
    property p_fall1; $fell(t1_irq_req) |-> $past(t1_irq_ack) || $past(psel && penable && pwrite); endproperty
    a_fall1: assert property (p_fall1) else $error("t1 request dropped");
    property p_ack0; t0_irq_ack ##1 !t0_irq_ack [*3] |-> !t0_irq_req; endproperty
    a_ack0: assert property (p_ack0) else $error("t0 ack ignored");
    property p_hold1; t1_irq_req && !t1_irq_ack && !(psel && penable && pwrite) |=> t1_irq_req; endproperty
    a_hold1: assert property (p_hold1) else $error("t1 request not held");
    c_ack0: cover property (t0_irq_ack && t0_irq_req);
    c_tick: cover property (t1_overflow_tick);
    c_err: cover property (pslverr);
endmodule : dual_timer_chk

/* File: bench/core_model.sv */
// Purpose: Processor core model, APB master and vectoring acks
// Assumes: Called right after a rising edge
// Notes:   Waits for pready, never assumes a latency
`timescale 1ns/1ps
module core_model (
    input  wire logic        clk_sys,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             t0_irq_ack,
    output logic             t1_irq_ack
);
    initial begin
        {psel, penable, pwrite, paddr, pwdata, t0_irq_ack, t1_irq_ack} = '0;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : xfer
    // Vectoring pulse, one cycle
    task automatic ack(input logic t1);
        if (t1) t1_irq_ack <= 1'b1; else t0_irq_ack <= 1'b1;
        @(posedge clk_sys);
        {t0_irq_ack, t1_irq_ack} <= 2'h0;
        @(posedge clk_sys);
    endtask : ack
endmodule : core_model

/* File: bench/tb.sv */
// Purpose: Self-checking bench for the dual timer
// Assumes: Zero-wait APB, tick every six clocks
// Notes:   Reads are timed to land before the next tick
`timescale 1ns/1ps
module tb;
    logic        clk_sys, reset_n, t0_count_pin, t1_count_pin, ext_irq_pin_zero, ext_irq_pin_one;
    logic        psel, penable, pwrite, pready, pslverr, t0_irq_ack, t1_irq_ack;
    logic        t0_irq_req, t1_irq_req, t1_overflow_tick, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q, q2;
    int          num_errors, tests_run;

    core_model u_core (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .t0_irq_ack(t0_irq_ack),
        .t1_irq_ack(t1_irq_ack));
    dual_timer u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .t0_count_pin(t0_count_pin), .t1_count_pin(t1_count_pin), .ext_irq_pin_zero(ext_irq_pin_zero),
        .ext_irq_pin_one(ext_irq_pin_one), .t0_irq_ack(t0_irq_ack), .t1_irq_ack(t1_irq_ack),
        .t0_irq_req(t0_irq_req), .t1_irq_req(t1_irq_req), .t1_overflow_tick(t1_overflow_tick));

    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_core.xfer(1'b1, a, {24'h0, d}, q2, e);
    endtask : wr
    task automatic rd(input string n, input logic [7:0] a, input logic [7:0] x);
        u_core.xfer(1'b0, a, 32'h0, q, e);
        chk(n, {24'h0, x}, q);
    endtask : rd
    task automatic wait_req(input logic t1);
        for (int n = 0; n < 1000 && (t1 ? t1_irq_req : t0_irq_req) !== 1'b1; n++) @(posedge clk_sys);
        chk("irq request", 1, t1 ? t1_irq_req : t0_irq_req);
    endtask : wait_req
    task automatic pulses(input int n);
        repeat (n) begin
            t0_count_pin <= 1'b1;
            repeat (12) @(posedge clk_sys);
            t0_count_pin <= 1'b0;
            repeat (12) @(posedge clk_sys);
        end
    endtask : pulses
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test

    task automatic test_reset();
        rd("control", timer_pkg::OFS_CONTROL, 8'h00);
        rd("mode", timer_pkg::OFS_MODE, 8'h00);
        u_core.xfer(1'b0, 8'h1c, 32'h0, q, e);
        chk("unmapped error", 1, e);
        $display("test reset done");
    endtask : test_reset
    task automatic test_reload();
        wr(timer_pkg::OFS_MODE, 8'h02);
        wr(timer_pkg::OFS_T0_HIGH, 8'hf0);
        wr(timer_pkg::OFS_T0_LOW, 8'hfe);
        wr(timer_pkg::OFS_IRQ_EN, 8'h82);
        wr(timer_pkg::OFS_CONTROL, 8'h10);
        wait_req(1'b0);
        rd("t0 low reload", timer_pkg::OFS_T0_LOW, 8'hf0);
        rd("t0 high kept", timer_pkg::OFS_T0_HIGH, 8'hf0);
        wr(timer_pkg::OFS_T0_HIGH, 8'h80);
        u_core.ack(1'b0);
        chk("t0 req after ack", 0, t0_irq_req);
        wait_req(1'b0);
        rd("t0 new reload", timer_pkg::OFS_T0_LOW, 8'h80);
        wr(timer_pkg::OFS_IRQ_EN, 8'h02);
        chk("masked req", 0, t0_irq_req);
        rd("flag kept", timer_pkg::OFS_CONTROL, 8'h30);
        wr(timer_pkg::OFS_CONTROL, 8'h00);
        $display("test reload done");
    endtask : test_reload
    task automatic test_prescale();
        wr(timer_pkg::OFS_MODE, 8'h00);
        wr(timer_pkg::OFS_T1_LOW, 8'hfe);
        wr(timer_pkg::OFS_T1_HIGH, 8'hff);
        wr(timer_pkg::OFS_IRQ_EN, 8'h88);
        wr(timer_pkg::OFS_CONTROL, 8'h40);
        wait_req(1'b1);
        rd("t1 high", timer_pkg::OFS_T1_HIGH, 8'h00);
        rd("t1 low", timer_pkg::OFS_T1_LOW, 8'he0);
        u_core.ack(1'b1);
        wr(timer_pkg::OFS_CONTROL, 8'h00);
        wr(timer_pkg::OFS_T1_LOW, 8'hff);
        wr(timer_pkg::OFS_T1_HIGH, 8'h12);
        wr(timer_pkg::OFS_MODE, 8'h10);
        wr(timer_pkg::OFS_CONTROL, 8'h40);
        repeat (8) @(posedge clk_sys);
        wr(timer_pkg::OFS_MODE, 8'h30);
        rd("t1 carry", timer_pkg::OFS_T1_HIGH, 8'h13);
        u_core.xfer(1'b0, timer_pkg::OFS_T1_LOW, 32'h0, q, e);
        chk("t1 low", 1, q[7:0] <= 8'h01);
        q2 = q;
        repeat (30) @(posedge clk_sys);
        rd("t1 held", timer_pkg::OFS_T1_LOW, q2[7:0]);
        wr(timer_pkg::OFS_CONTROL, 8'h00);
        wr(timer_pkg::OFS_T1_HIGH, 8'hc0);
        wr(timer_pkg::OFS_T1_LOW, 8'hff);
        wr(timer_pkg::OFS_MODE, 8'h20);
        wr(timer_pkg::OFS_CONTROL, 8'h40);
        wait_req(1'b1);
        chk("baud tick", 1, t1_overflow_tick);
        rd("t1 low reload", timer_pkg::OFS_T1_LOW, 8'hc0);
        rd("t1 high kept", timer_pkg::OFS_T1_HIGH, 8'hc0);
        u_core.ack(1'b1);
        wr(timer_pkg::OFS_CONTROL, 8'h00);
        $display("test timer 1 done");
    endtask : test_prescale
    task automatic test_gate();
        wr(timer_pkg::OFS_T0_LOW, 8'h00);
        wr(timer_pkg::OFS_MODE, 8'h0d);
        wr(timer_pkg::OFS_CONTROL, 8'h10);
        pulses(2);
        rd("gated off", timer_pkg::OFS_T0_LOW, 8'h00);
        ext_irq_pin_zero <= 1'b1;
        pulses(3);
        rd("edges counted", timer_pkg::OFS_T0_LOW, 8'h03);
        wr(timer_pkg::OFS_CONTROL, 8'h00);
        $display("test gate done");
    endtask : test_gate
    task automatic test_split();
        wr(timer_pkg::OFS_MODE, 8'h33);
        wr(timer_pkg::OFS_T0_LOW, 8'h00);
        wr(timer_pkg::OFS_T0_HIGH, 8'hfe);
        wr(timer_pkg::OFS_CONTROL, 8'h40);
        wait_req(1'b1);
        rd("split high", timer_pkg::OFS_T0_HIGH, 8'h00);
        rd("split low idle", timer_pkg::OFS_T0_LOW, 8'h00);
        $display("test split done");
    endtask : test_split

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        stop_test();
    end
    initial begin
        {reset_n, t0_count_pin, t1_count_pin, ext_irq_pin_zero, ext_irq_pin_one} = '0;
        num_errors = 0;
        tests_run  = 0;
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        test_reset();
        test_reload();
        test_prescale();
        test_gate();
        test_split();
        stop_test();
    end
endmodule : tb

bind dual_timer dual_timer_chk u_chk (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .t0_irq_ack(t0_irq_ack),
    .t1_irq_ack(t1_irq_ack), .t0_irq_req(t0_irq_req), .t1_irq_req(t1_irq_req),
    .t1_overflow_tick(t1_overflow_tick));
